// File: pcit_pkg.sv
package pcit_pkg;

  localparam int unsigned PCIT_CLK_HZ = 25_000_000;

  localparam int unsigned PCIT_ADDR_W = 16;

  // Every instruction finishes within this many clocks, divide being the longest.
  localparam logic [3:0] PCIT_MAX_CYC = 4'h8;

  localparam logic [15:0] PCIT_PC_RST = 16'h0000;

  // Bit positions inside the program store control field.
  localparam int unsigned PCIT_PSC_SEL   = 0;
  localparam int unsigned PCIT_PSC_ERASE = 1;

  localparam logic [7:0] PCIT_OP_DIV      = 8'h84;
  localparam logic [7:0] PCIT_OP_MUL      = 8'hA4;
  localparam logic [7:0] PCIT_OP_INCREMENT_DATA_POINTER = 8'hA3;

  typedef enum logic {
    PCIT_PH_IDLE = 1'b0,
    PCIT_PH_EXEC = 1'b1
  } pcit_phase_t;

  typedef struct packed {
    logic [1:0] bytes;
    logic [3:0] cyc;
    logic       cond;
    logic       jump;
    logic       xmove;
    logic       cmove;
  } pcit_timing_t;

  // Timing classes: bytes, clocks (branch not taken), conditional, jump, data move, code move.
  localparam pcit_timing_t PCIT_T_REG   = '{2'h1, 4'h1, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam pcit_timing_t PCIT_T_DIR   = '{2'h2, 4'h2, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam pcit_timing_t PCIT_T_IND   = '{2'h1, 4'h2, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam pcit_timing_t PCIT_T_DIR3  = '{2'h3, 4'h3, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam pcit_timing_t PCIT_T_DIV   = '{2'h1, 4'h8, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam pcit_timing_t PCIT_T_MUL   = '{2'h1, 4'h4, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam pcit_timing_t PCIT_T_BR2   = '{2'h2, 4'h2, 1'b1, 1'b0, 1'b0, 1'b0};
  localparam pcit_timing_t PCIT_T_BR3   = '{2'h3, 4'h3, 1'b1, 1'b0, 1'b0, 1'b0};
  localparam pcit_timing_t PCIT_T_AJMP  = '{2'h2, 4'h3, 1'b0, 1'b1, 1'b0, 1'b0};
  localparam pcit_timing_t PCIT_T_LJMP  = '{2'h3, 4'h4, 1'b0, 1'b1, 1'b0, 1'b0};
  localparam pcit_timing_t PCIT_T_RET   = '{2'h1, 4'h5, 1'b0, 1'b1, 1'b0, 1'b0};
  localparam pcit_timing_t PCIT_T_JMPI  = '{2'h1, 4'h3, 1'b0, 1'b1, 1'b0, 1'b0};
  localparam pcit_timing_t PCIT_T_CMOVE = '{2'h1, 4'h3, 1'b0, 1'b0, 1'b0, 1'b1};
  localparam pcit_timing_t PCIT_T_XMOVE = '{2'h1, 4'h3, 1'b0, 1'b0, 1'b1, 1'b0};

  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic        taken;
    logic [15:0] target;
    logic [15:0] data_addr;
  } pcit_issue_t;

  typedef struct packed {
    logic        halt_req;
    logic        resume;
    logic        step;
    logic        bkpt_en;
    logic [15:0] bkpt_addr;
    logic        watch_en;
    logic [15:0] watch_addr;
  } pcit_dbg_t;

  typedef struct packed {
    pcit_phase_t phase;
    logic [3:0]  cnt;
    logic        ready;
    logic        done;
    logic [1:0]  bytes;
    logic [3:0]  cycles;
    logic [15:0] pc;
    logic        halted;
    logic        step_armed;
    logic        skip_bkpt;
    logic        bkpt_hit;
    logic        watch_hit;
    logic        watch_arm;
    logic        xflash;
    logic        xram;
    logic        xwrite;
    logic        erase;
    logic        cread;
  } pcit_state_t;

  localparam pcit_state_t PCIT_STATE_RST = '{ready: 1'b1, pc: PCIT_PC_RST, phase: PCIT_PH_IDLE, default: '0};

endpackage

// File: pcit_core_timing.sv
// Function
// RULE_01: Count every instruction in plain clocks, no machine-cycle grouping.
// RULE_02: No instruction exceeds eight clocks; divide is one byte, eight clocks.
// RULE_03: Untaken conditional branch finishes one clock sooner than a taken one.
// RULE_04: Most instructions take one clock per program byte.
// RULE_05: 109 instructions; 26 in one clock, 50 in two, rest two to eight.
// RULE_06: Opcode encodings and addressing modes match the classic instruction set.
// RULE_07: Arithmetic: register 1/1, direct and immediate 2/2, indirect 1/2.
// RULE_08: Increment/decrement: accumulator or register 1 clock, direct or indirect 2.
// RULE_09: Data pointer increment is one byte and one clock.
// RULE_10: Logic immediate-to-direct is 3/3; accumulator-to-direct is 2/2.
// RULE_11: Clear, complement and rotate accumulator are one byte, one clock.
// RULE_12: Peak rate is one instruction per clock at 25 MHz.
// RULE_13: Software reads and modifies program flash bytewise via code and data moves.
// RULE_14: Data move is steered to program flash when program store control selects it.
// RULE_15: Data move reaches mapped RAM when program store control selects data space.
// RULE_16: Breakpoints, watchpoints, halt, resume and single step without using resources.
// RULE_17: A completion pulse marks the last clock of each instruction.
module pcit_core_timing #(
  parameter int unsigned ADDR_W = pcit_pkg::PCIT_ADDR_W
) (
  input  wire logic               i_clk,
  input  wire logic               i_arst_n,
  input  wire pcit_pkg::pcit_issue_t i_issue,
  input  wire logic [1:0]         i_program_store_control,
  input  wire pcit_pkg::pcit_dbg_t   i_dbg,
  output logic                    o_ready,
  output logic                    o_done,
  output logic [1:0]              o_bytes,
  output logic [3:0]              o_cycles,
  output logic [ADDR_W-1:0]       o_pc,
  output logic                    o_halted,
  output logic                    o_bkpt_hit,
  output logic                    o_watch_hit,
  output logic                    o_xmove_flash,
  output logic                    o_xmove_ram,
  output logic                    o_xmove_write,
  output logic                    o_flash_erase,
  output logic                    o_code_read
);
  import pcit_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode timing decode.

  // RULE_05: every code timed
  // RULE_06: classic encoding map
  function automatic pcit_timing_t pcit_decode(input logic [7:0] op);
    logic [3:0]   hi;
    logic [3:0]   lo;
    pcit_timing_t t;
    hi = op[7:4];
    lo = op[3:0];
    t  = PCIT_T_REG;
    if (lo[3]) begin
      case (hi)
        4'h7, 4'h8, 4'hA: t = PCIT_T_DIR;
        4'hB:             t = PCIT_T_BR3;
        4'hD:             t = PCIT_T_BR2;
        default:          t = PCIT_T_REG;
      endcase
    end else if (lo[3:1] == 3'h3) begin
      case (hi)
        4'h7, 4'h8, 4'hA: t = PCIT_T_DIR;
        4'hB:             t = PCIT_T_BR3;
        default:          t = PCIT_T_IND;
      endcase
    end else begin
      case (lo)
        4'h5: begin
          case (hi)
            4'h7, 4'h8: t = PCIT_T_DIR3;
            4'hA:       t = PCIT_T_REG;
            4'hB, 4'hD: t = PCIT_T_BR3;
            default:    t = PCIT_T_DIR;
          endcase
        end
        4'h4: begin
          case (hi)
            4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: t = PCIT_T_REG;
            4'h8:    t = PCIT_T_DIV;
            4'hA:    t = PCIT_T_MUL;
            4'hB:    t = PCIT_T_BR3;
            default: t = PCIT_T_DIR;
          endcase
        end
        4'h3: begin
          case (hi)
            4'h4, 4'h5, 4'h6: t = PCIT_T_DIR3;
            4'h7:             t = PCIT_T_JMPI;
            4'h8, 4'h9:       t = PCIT_T_CMOVE;
            4'hE, 4'hF:       t = PCIT_T_XMOVE;
            default:          t = PCIT_T_REG;
          endcase
        end
        4'h2: begin
          case (hi)
            4'h0, 4'h1: t = PCIT_T_LJMP;
            4'h2, 4'h3: t = PCIT_T_RET;
            4'hE, 4'hF: t = PCIT_T_XMOVE;
            default:    t = PCIT_T_DIR;
          endcase
        end
        4'h1: t = PCIT_T_AJMP;
        default: begin
          case (hi)
            4'h0:                   t = PCIT_T_REG;
            4'h1, 4'h2, 4'h3:       t = PCIT_T_BR3;
            4'h4, 4'h5, 4'h6, 4'h7: t = PCIT_T_BR2;
            4'h8:                   t = PCIT_T_AJMP;
            4'h9:                   t = PCIT_T_DIR3;
            4'hE, 4'hF:             t = PCIT_T_XMOVE;
            default:                t = PCIT_T_DIR;
          endcase
        end
      endcase
    end
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  pcit_state_t  s;
  pcit_state_t  next_s;
  pcit_timing_t dec;
  logic         accept;
  logic [3:0]   cyc;
  logic         boundary;
  logic         bkpt_match;
  logic         watch_pend;

  assign dec    = pcit_decode(i_issue.opcode);
  // RULE_12: accept one per clock
  assign accept = i_issue.valid & s.ready;

  always_comb begin
    next_s           = s;
    next_s.done      = 1'b0;
    next_s.bkpt_hit  = 1'b0;
    next_s.watch_hit = 1'b0;
    watch_pend       = 1'b0;
    bkpt_match       = 1'b0;
    // RULE_03: taken adds one clock
    cyc      = dec.cyc + {3'h0, dec.cond & i_issue.taken};
    boundary = 1'b0;
    // Access strobes stand from the first clock through the completion clock.
    if (s.done) begin
      next_s.xflash = 1'b0;
      next_s.xram   = 1'b0;
      next_s.xwrite = 1'b0;
      next_s.erase  = 1'b0;
      next_s.cread  = 1'b0;
    end
    if (s.phase == PCIT_PH_EXEC) begin
      // RULE_01: one count per clock
      if (s.cnt == 4'h1) begin
        next_s.phase = PCIT_PH_IDLE;
        // RULE_17: completion pulse
        next_s.done  = 1'b1;
        boundary     = 1'b1;
      end else begin
        next_s.cnt = s.cnt - 4'h1;
      end
    end else if (accept) begin
      // RULE_04: byte count from decode
      next_s.bytes      = dec.bytes;
      next_s.cycles     = cyc;
      next_s.step_armed = 1'b0;
      next_s.skip_bkpt  = 1'b0;
      if (dec.jump | (dec.cond & i_issue.taken)) begin
        next_s.pc = i_issue.target;
      end else begin
        next_s.pc = s.pc + {14'h0, dec.bytes};
      end
      // RULE_14: flash selected by control
      next_s.xflash = dec.xmove & i_program_store_control[PCIT_PSC_SEL];
      // RULE_15: data space otherwise
      next_s.xram   = dec.xmove & ~i_program_store_control[PCIT_PSC_SEL];
      // RULE_13: bytewise flash access
      next_s.xwrite = dec.xmove & i_issue.opcode[4];
      next_s.erase  = dec.xmove & i_issue.opcode[4] & i_program_store_control[PCIT_PSC_SEL]
                      & i_program_store_control[PCIT_PSC_ERASE];
      next_s.cread  = dec.cmove;
      next_s.watch_arm = i_dbg.watch_en & dec.xmove & (i_issue.data_addr == i_dbg.watch_addr);
      if (cyc == 4'h1) begin
        next_s.done = 1'b1;
        boundary    = 1'b1;
      end else begin
        next_s.phase = PCIT_PH_EXEC;
        next_s.cnt   = cyc - 4'h1;
      end
    end else begin
      boundary = 1'b1;
    end
    next_s.ready = 1'b0;
    if (boundary) begin
      // RULE_16: debug at instruction boundaries
      bkpt_match = i_dbg.bkpt_en & (next_s.pc == i_dbg.bkpt_addr) & ~next_s.skip_bkpt;
      watch_pend       = next_s.watch_arm;
      next_s.watch_arm = 1'b0;
      if (next_s.halted & i_dbg.resume) begin
        next_s.halted    = 1'b0;
        next_s.skip_bkpt = 1'b1;
      end else if (~next_s.halted & (i_dbg.halt_req | bkpt_match | watch_pend)) begin
        next_s.halted    = 1'b1;
        next_s.bkpt_hit  = bkpt_match;
        next_s.watch_hit = watch_pend;
      end
      if (next_s.halted & i_dbg.step) begin
        next_s.step_armed = 1'b1;
      end
      next_s.ready = ~next_s.halted | next_s.step_armed;
    end
  end

  // A watched data move is caught at issue and held until it completes, so the halt is raised on its completion clock.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= PCIT_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign o_ready       = s.ready;
  assign o_done        = s.done;
  assign o_bytes       = s.bytes;
  assign o_cycles      = s.cycles;
  assign o_pc          = s.pc[ADDR_W-1:0];
  assign o_halted      = s.halted;
  assign o_bkpt_hit    = s.bkpt_hit;
  assign o_watch_hit   = s.watch_hit;
  assign o_xmove_flash = s.xflash;
  assign o_xmove_ram   = s.xram;
  assign o_xmove_write = s.xwrite;
  assign o_flash_erase = s.erase;
  assign o_code_read   = s.cread;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic [3:0] elapsed;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      elapsed <= 4'h0;
    end else if (accept) begin
      elapsed <= 4'h1;
    end else if (s.phase == PCIT_PH_EXEC) begin
      elapsed <= elapsed + 4'h1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_count_matches: assert property (o_done |-> elapsed == o_cycles) // RULE_01
    else $error("completion clock count differs from reported cycles");
  a_max_eight: assert property (o_done |-> (o_cycles >= 4'h1) && (o_cycles <= PCIT_MAX_CYC)) // RULE_02
    else $error("instruction cycle count out of range");
  a_div_eight_clk: assert property ((accept && i_issue.opcode == PCIT_OP_DIV) // RULE_02
      |=> !o_done [*7] ##1 (o_done && o_cycles == 4'h8 && o_bytes == 2'h1))
    else $error("divide did not take eight clocks");
  a_branch_extra: assert property ((accept && dec.cond) // RULE_03
      |=> o_cycles == {2'h0, o_bytes} + {3'h0, $past(i_issue.taken)})
    else $error("branch taken penalty wrong");
  a_arith_reg_ind: assert property ((accept && i_issue.opcode[7:4] inside {4'h2, 4'h3, 4'h9} // RULE_07
      && i_issue.opcode[3:1] == 3'h3) |=> !o_done ##1 (o_done && o_bytes == 2'h1 && o_cycles == 4'h2))
    else $error("indirect arithmetic timing wrong");
  a_inc_dec_reg: assert property ((accept && i_issue.opcode[7:5] == 3'h0 // RULE_08
      && i_issue.opcode[3]) |=> o_done && o_cycles == 4'h1)
    else $error("register increment not one clock");
  a_increment_data_pointer_one: assert property ((accept && i_issue.opcode == PCIT_OP_INCREMENT_DATA_POINTER) // RULE_09
      |=> o_done && o_bytes == 2'h1 && o_cycles == 4'h1)
    else $error("data pointer increment not one clock");
  a_logic_dir_imm: assert property ((accept && i_issue.opcode inside {8'h43, 8'h53, 8'h63}) // RULE_10
      |-> ##3 (o_done && o_bytes == 2'h3 && o_cycles == 4'h3))
    else $error("logic immediate to direct not three clocks");
  a_acc_unary: assert property ((accept && i_issue.opcode inside {8'hE4, 8'hF4, 8'h03, 8'h13, 8'h23, 8'h33}) // RULE_11
      |=> o_done && o_cycles == 4'h1)
    else $error("accumulator operation not one clock");
  a_back_to_back: assert property ((accept && dec.cyc == 4'h1 && !dec.cond && !s.halted // RULE_12
      && !i_dbg.halt_req && !i_dbg.bkpt_en) |=> o_ready)
    else $error("single clock instruction blocked the next issue");
  a_xmove_steer: assert property ((accept && dec.xmove) // RULE_14
      |=> o_xmove_flash == $past(i_program_store_control[PCIT_PSC_SEL]) && o_xmove_ram != o_xmove_flash)
    else $error("data move steered to wrong space");
  a_halt_blocks: assert property ((o_halted && !s.step_armed) |-> !o_ready) // RULE_16
    else $error("halted core accepts instructions");

  // The return, direct arithmetic, memory increment and logic checks use literal opcode lists so that a slip in the decode cannot hide itself.
  a_cycle_set: assert property (o_done |-> o_cycles inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8}) // RULE_05
    else $error("cycle count outside the instruction table");
  a_mul_four: assert property ((accept && i_issue.opcode == PCIT_OP_MUL) // RULE_05
      |=> !o_done [*3] ##1 (o_done && o_cycles == 4'h4 && o_bytes == 2'h1))
    else $error("multiply did not take four clocks");
  a_return_five: assert property ((accept && i_issue.opcode inside {8'h22, 8'h32}) // RULE_05
      |=> !o_done [*4] ##1 (o_done && o_cycles == 4'h5 && o_bytes == 2'h1))
    else $error("return did not take five clocks");
  a_done_once: assert property ((o_done && !accept) |=> !o_done) // RULE_17
    else $error("completion pulse longer than one clock");
  a_bytes_advance: assert property ((accept && !dec.jump && !(dec.cond && i_issue.taken)) // RULE_04
      |=> o_pc == $past(o_pc) + {14'h0, o_bytes})
    else $error("program counter did not advance by the byte count");
  a_jump_target: assert property ((accept && (dec.jump || (dec.cond && i_issue.taken))) // RULE_06
      |=> o_pc == $past(i_issue.target))
    else $error("jump did not land on its target");
  a_arith_reg: assert property ((accept && i_issue.opcode[7:4] inside {4'h2, 4'h3, 4'h9} // RULE_07
      && i_issue.opcode[3]) |=> (o_done && o_bytes == 2'h1 && o_cycles == 4'h1))
    else $error("register arithmetic timing wrong");
  a_arith_direct: assert property ((accept && i_issue.opcode inside {8'h24, 8'h25, 8'h34, 8'h35, 8'h94, 8'h95}) // RULE_07
      |=> !o_done ##1 (o_done && o_bytes == 2'h2 && o_cycles == 4'h2))
    else $error("direct or immediate arithmetic timing wrong");
  a_inc_dec_mem: assert property ((accept && i_issue.opcode inside {8'h05, 8'h15, 8'h06, 8'h07, 8'h16, 8'h17}) // RULE_08
      |=> !o_done ##1 (o_done && o_cycles == 4'h2))
    else $error("memory increment or decrement not two clocks");
  a_logic_acc_dir: assert property ((accept && i_issue.opcode inside {8'h42, 8'h52, 8'h62}) // RULE_10
      |=> !o_done ##1 (o_done && o_bytes == 2'h2 && o_cycles == 4'h2))
    else $error("logic accumulator to direct not two clocks");
  a_ready_after_done: assert property ((o_done && !o_halted) |-> o_ready) // RULE_12
    else $error("core not ready on the completion clock");
  a_code_read: assert property ((accept && dec.cmove) // RULE_13
      |=> o_code_read && !o_xmove_flash && !o_xmove_ram)
    else $error("code byte move strobes wrong");
  a_xmove_ram: assert property ((accept && dec.xmove && !i_program_store_control[PCIT_PSC_SEL]) // RULE_15
      |=> o_xmove_ram && !o_xmove_flash)
    else $error("data move missed the data space");
  a_bkpt_halt: assert property (o_bkpt_hit |-> o_halted) // RULE_16
    else $error("breakpoint hit without halt");
  a_watch_halt: assert property (o_watch_hit |-> o_halted && o_done) // RULE_16
    else $error("watchpoint hit away from the completion clock");

  c_div_run: cover property (accept && i_issue.opcode == PCIT_OP_DIV);
  c_taken_branch: cover property (accept && dec.cond && i_issue.taken);
  c_peak_rate: cover property (o_done [*4]);
  c_single_step: cover property (o_halted && accept ##[1:8] o_done && o_halted);

endmodule

// File: pcit_mem_model.sv
// Far-side memory model: counts completed flash, mapped-RAM and code accesses.
module pcit_mem_model (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_done,
  input  wire logic       i_flash,
  input  wire logic       i_ram,
  input  wire logic       i_code,
  output logic      [7:0] o_flash_cnt,
  output logic      [7:0] o_ram_cnt,
  output logic      [7:0] o_code_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // Accesses are counted at completion because the strobes stand for several clocks.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_flash_cnt <= 8'h00;
      o_ram_cnt   <= 8'h00;
      o_code_cnt  <= 8'h00;
    end else if (i_done) begin
      if (i_flash) o_flash_cnt <= o_flash_cnt + 8'h01;
      if (i_ram) o_ram_cnt <= o_ram_cnt + 8'h01;
      if (i_code) o_code_cnt <= o_code_cnt + 8'h01;
    end
  end
endmodule

// File: test_pipelined_core_instruction_timing.sv
module test_pipelined_core_instruction_timing;
  timeunit 1ns;
  timeprecision 1ps;
  import pcit_pkg::*;
  localparam logic [15:0] TGT = 16'h0100;
  // Entries are opcode, byte count and clock count.
  localparam logic [15:0] TAB [22] = '{16'h2811, 16'h2522, 16'h2612, 16'h2422, 16'h0411, 16'h0811,
    16'h0522, 16'h0612, 16'h1411, 16'hA311, 16'hA414, 16'h8418, 16'h5333, 16'h4333, 16'h6333,
    16'h5222, 16'hE411, 16'hF411, 16'h2311, 16'h3311, 16'h0311, 16'h1311};
  logic              i_clk = 1'b0;
  logic              i_arst_n = 1'b0;
  pcit_issue_t       iss = '0;
  logic        [1:0] psc = 2'h0;
  pcit_dbg_t         dbg = '0;
  logic              o_ready, o_done, o_halted, o_bkpt_hit, o_watch_hit;
  logic        [1:0] o_bytes;
  logic        [3:0] o_cycles;
  logic       [15:0] o_pc;
  logic              o_xmove_flash, o_xmove_ram, o_xmove_write, o_flash_erase, o_code_read;
  logic        [7:0] fl_cnt, ram_cnt, code_cnt;
  logic        [4:0] seen = 5'h00;
  logic       [15:0] exp_pc = 16'h0000;
  int                errors = 0;
  int                n_checks = 0;

  always #20 i_clk = ~i_clk;

  pcit_core_timing dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_issue(iss), .i_program_store_control(psc),
    .i_dbg(dbg), .o_ready(o_ready), .o_done(o_done), .o_bytes(o_bytes), .o_cycles(o_cycles), .o_pc(o_pc),
    .o_halted(o_halted), .o_bkpt_hit(o_bkpt_hit), .o_watch_hit(o_watch_hit), .o_xmove_flash(o_xmove_flash),
    .o_xmove_ram(o_xmove_ram), .o_xmove_write(o_xmove_write), .o_flash_erase(o_flash_erase),
    .o_code_read(o_code_read));

  pcit_mem_model mem (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_done(o_done), .i_flash(o_xmove_flash),
    .i_ram(o_xmove_ram), .i_code(o_code_read), .o_flash_cnt(fl_cnt), .o_ram_cnt(ram_cnt),
    .o_code_cnt(code_cnt));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Offers one instruction, then times it from accept to the completion pulse.
  task automatic issue(input logic [7:0] op, input logic tk, input logic [1:0] b, input logic [3:0] c);
    int n;
    n = 0;
    @(posedge i_clk);
    iss.valid <= 1'b1;
    iss.opcode <= op;
    iss.taken <= tk;
    iss.target <= TGT;
    @(negedge i_clk);
    while (o_ready !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    @(posedge i_clk);
    iss.valid <= 1'b0;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_done !== 1'b1 && n < 12);
    seen = {o_xmove_flash, o_xmove_ram, o_xmove_write, o_flash_erase, o_code_read};
    exp_pc = tk ? TGT : exp_pc + 16'(b);
    chk(16'(n), 16'(c));
    chk(16'(o_cycles), 16'(c));
    chk(16'(o_bytes), 16'(b));
    chk(o_pc, exp_pc);
  endtask

  task automatic wait_hit(input bit watch);
    int n;
    n = 0;
    while ((watch ? o_watch_hit : o_bkpt_hit) !== 1'b1 && n < 4) begin
      @(negedge i_clk);
      n++;
    end
    chk(16'(watch ? o_watch_hit : o_bkpt_hit), 16'h0001);
    @(negedge i_clk);
    chk(16'(o_halted), 16'h0001);
  endtask

  task automatic pulse_resume;
    @(posedge i_clk);
    dbg.resume <= 1'b1;
    @(posedge i_clk);
    dbg.resume <= 1'b0;
    @(negedge i_clk);
    chk(16'(o_halted), 16'h0000);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    repeat (5) @(posedge i_clk);
    chk(16'({o_ready, o_done, o_halted, o_bkpt_hit, o_watch_hit}), 16'h0010);
    chk(o_pc, 16'h0000);
    i_arst_n <= 1'b1;
  endtask

  task automatic t_table;
    for (int i = 0; i < 22; i++) issue(TAB[i][15:8], 1'b0, TAB[i][5:4], TAB[i][3:0]);
  endtask

  task automatic t_branch;
    issue(8'h60, 1'b0, 2'h2, 4'h2);
    issue(8'h60, 1'b1, 2'h2, 4'h3);
    issue(8'h20, 1'b0, 2'h3, 4'h3);
    issue(8'h20, 1'b1, 2'h3, 4'h4);
    issue(8'h22, 1'b1, 2'h1, 4'h5);
    issue(8'h02, 1'b1, 2'h3, 4'h4);
  endtask

  // Nine one-clock instructions offered back to back must complete one per clock.
  task automatic t_rate;
    int cnt;
    cnt = 0;
    @(posedge i_clk);
    iss.valid <= 1'b1;
    iss.opcode <= 8'h00;
    iss.taken <= 1'b0;
    @(posedge i_clk);
    repeat (8) begin
      @(negedge i_clk);
      cnt += int'(o_done === 1'b1);
    end
    @(posedge i_clk);
    iss.valid <= 1'b0;
    @(negedge i_clk);
    exp_pc = exp_pc + 16'h0009;
    chk(16'(cnt), 16'h0008);
    chk(o_pc, exp_pc);
  endtask

  task automatic t_xmove;
    @(posedge i_clk);
    psc <= 2'h1;
    issue(8'hE0, 1'b0, 2'h1, 4'h3);
    chk(16'(seen), 16'h0010);
    @(posedge i_clk);
    psc <= 2'h3;
    issue(8'hF0, 1'b0, 2'h1, 4'h3);
    chk(16'(seen), 16'h0016);
    @(posedge i_clk);
    psc <= 2'h0;
    issue(8'hF0, 1'b0, 2'h1, 4'h3);
    chk(16'(seen), 16'h000C);
    issue(8'hE0, 1'b0, 2'h1, 4'h3);
    chk(16'(seen), 16'h0008);
    issue(8'h93, 1'b0, 2'h1, 4'h3);
    chk(16'(seen), 16'h0001);
  endtask

  task automatic t_debug;
    @(posedge i_clk);
    dbg.halt_req <= 1'b1;
    @(negedge i_clk);
    @(negedge i_clk);
    chk(16'({o_halted, o_ready}), 16'h0002);
    @(posedge i_clk);
    dbg.halt_req <= 1'b0;
    iss.valid <= 1'b1;
    iss.opcode <= 8'h00;
    repeat (3) begin
      @(negedge i_clk);
      chk(16'(o_done), 16'h0000);
      chk(o_pc, exp_pc);
    end
    @(posedge i_clk);
    iss.valid <= 1'b0;
    dbg.step <= 1'b1;
    @(posedge i_clk);
    dbg.step <= 1'b0;
    issue(8'h00, 1'b0, 2'h1, 4'h1);
    @(negedge i_clk);
    chk(16'({o_halted, o_ready}), 16'h0002);
    pulse_resume;
    @(posedge i_clk);
    dbg.bkpt_en <= 1'b1;
    dbg.bkpt_addr <= exp_pc + 16'h0001;
    issue(8'h00, 1'b0, 2'h1, 4'h1);
    wait_hit(1'b0);
    pulse_resume;
    // The breakpoint address is passed once after resume, so this must not halt.
    issue(8'h00, 1'b0, 2'h1, 4'h1);
    @(posedge i_clk);
    dbg.bkpt_en <= 1'b0;
    dbg.watch_en <= 1'b1;
    dbg.watch_addr <= 16'h0042;
    iss.data_addr <= 16'h0042;
    issue(8'hE0, 1'b0, 2'h1, 4'h3);
    wait_hit(1'b1);
    pulse_resume;
  endtask

  initial begin
    #(40 * 4000);
    errors++;
    conclude;
  end

  initial begin
    t_reset;
    t_table;
    t_branch;
    t_rate;
    t_xmove;
    t_debug;
    chk({fl_cnt, ram_cnt}, 16'h0203);
    chk(16'(code_cnt), 16'h0001);
    conclude;
  end
endmodule
